// [include/qdh_pkg.sv]
// Package for the quad converter parallel-port host controller
package qdh_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam int CLK_MHZ = 50;
  // Setup, strobe width and hold times in ns (plain defaults)
  localparam int T_SETUP_NS = 40;
  localparam int T_STROBE_NS = 60;
  localparam int T_HOLD_NS = 20;
  localparam int T_SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 2'h0;

  typedef enum logic [2:0] {
    QDH_IDLE   = 3'b000,
    QDH_SETUP  = 3'b001,
    QDH_WSTRB  = 3'b010,
    QDH_HOLD   = 3'b011,
    QDH_LSTRB  = 3'b100,
    QDH_LHOLD  = 3'b101
  } qdh_state_e;

  typedef struct packed {
    qdh_state_e              st;
    logic [CNT_W-1:0]        cnt;
    logic [DATA_W-1:0]       data;
    logic [ADDR_W-1:0]       addr;
    logic                    load_after;
    logic                    wr_n;
    logic                    ld_n;
    logic                    a0_oe;
    logic                    pd;
    logic                    busy;
    logic                    done;
  } qdh_state_s;
endpackage

// [hdl/qdh_host.sv]
// Host controller driving the parallel port of a quad 8-bit voltage converter

//
// Timing
// Setup, strobe width and hold come from the package in ns and are rounded up to whole
// clock cycles, so the rounding only ever lengthens the margins, never shortens them.
// One shared down-counter times every phase; the state says which phase it is.
//
// Requests
// A request is taken only in idle, and never while power-down is asked for, because the
// low address line is then released and the device would read no valid channel.
// Requests that arrive while busy or while power_down is high are dropped without a flag; the user
// watches busy and powered_down before raising req_valid.
//
// Modes
// Power-down is a level input applied only between transfers; transparent is also read at the end
// of the write hold, where it decides the load, and at the end of the load strobe, where it sets the rest level.
// In transparent mode the load strobe rests low, and a load after a write is skipped
// since the device already follows its input registers.
//
// Limitations
// The host cannot see a device power-on reset; after one it assumes zero codes, just
// as it does after its own reset.
// The data bus is never released: the device pins are inputs only.
module qdh_host
  import qdh_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // User request side
  input  wire logic              req_valid,
  input  wire logic [1:0]        req_chan,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              req_load,
  input  wire logic              load_only,
  input  wire logic              transparent,
  input  wire logic              power_down,
  output logic                   busy,
  output logic                   done,
  output logic                   powered_down,
  // Device pins
  output logic [DATA_W-1:0]      data_bus,
  output logic                   addr_high_bit,
  output logic                   addr_low_or_powerdown_o,
  output logic                   addr_low_or_powerdown_oe,
  output logic                   write_strobe_n,
  output logic                   load_all_strobe_n
);
  qdh_state_s s_q, s_d;

  // Shared dwell counter: each timed state counts down to one, then moves on
  logic             cnt_last;
  logic [CNT_W-1:0] cnt_dec;
  // Request qualification
  logic             take_req;
  logic             take_write;
  logic             take_load;
  logic             want_load;

  always_comb begin
    cnt_last   = (s_q.cnt <= CNT_W'(1));
    cnt_dec    = s_q.cnt - CNT_W'(1);
    // Taken only from idle and never while power_down asks for the shared address pin to be released
    take_req   = (s_q.st == QDH_IDLE) && !power_down && req_valid;
    take_write = take_req && !load_only;
    take_load  = take_req && load_only;
    // A load strobe after the write is redundant while the copy is transparent
    want_load  = s_q.load_after && !transparent;
  end

  // State walk of one transfer, cycles at the default clock:
  //   IDLE  -> SETUP  data and address settle, 2 cycles
  //   SETUP -> WSTRB  write strobe low, 3 cycles
  //   WSTRB -> HOLD   strobe high, data kept, 1 cycle
  //   HOLD  -> LSTRB  only with a load request: load strobe low, 3 cycles
  //   LSTRB -> LHOLD  load strobe back to its rest level (high, low if transparent), 1 cycle
  //   LHOLD -> IDLE   done pulses for one cycle
  // A load-only request enters LSTRB straight from IDLE.

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      QDH_IDLE: begin
        // Idle levels follow the mode inputs; pd and a0_oe are not touched mid-transfer, ld_n is also set at the end of LSTRB
        s_d.ld_n  = ~transparent;
        s_d.pd    = power_down;
        s_d.a0_oe = ~power_down;
        s_d.busy  = 1'b0;
        if (take_load) begin
          s_d.busy = 1'b1;
          s_d.ld_n = 1'b0;
          s_d.cnt  = CNT_W'(T_STROBE_CYC);
          s_d.st   = QDH_LSTRB;
        end
        if (take_write) begin
          s_d.busy       = 1'b1;
          s_d.data       = req_data;
          s_d.addr       = req_chan;
          s_d.load_after = req_load;
          s_d.cnt        = CNT_W'(T_SETUP_CYC);
          s_d.st         = QDH_SETUP;
        end
      end

      QDH_SETUP: begin
        s_d.cnt = cnt_dec;
        if (cnt_last) begin
          s_d.wr_n = 1'b0;
          s_d.cnt  = CNT_W'(T_STROBE_CYC);
          s_d.st   = QDH_WSTRB;
        end
      end

      QDH_WSTRB: begin
        s_d.cnt = cnt_dec;
        if (cnt_last) begin
          s_d.wr_n = 1'b1;
          s_d.cnt  = CNT_W'(T_HOLD_CYC);
          s_d.st   = QDH_HOLD;
        end
      end

      QDH_HOLD: begin
        s_d.cnt = cnt_dec;
        if (cnt_last) begin
          if (want_load) begin
            s_d.ld_n = 1'b0;
            s_d.cnt  = CNT_W'(T_STROBE_CYC);
            s_d.st   = QDH_LSTRB;
          end else begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st   = QDH_IDLE;
          end
        end
      end

      QDH_LSTRB: begin
        s_d.cnt = cnt_dec;
        if (cnt_last) begin
          s_d.ld_n = ~transparent;
          s_d.cnt  = CNT_W'(T_HOLD_CYC);
          s_d.st   = QDH_LHOLD;
        end
      end

      QDH_LHOLD: begin
        s_d.cnt = cnt_dec;
        if (cnt_last) begin
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
          s_d.st   = QDH_IDLE;
        end
      end

      default: begin
        // Unreachable codes: park with both strobes released and the pin driven
        s_d.st         = QDH_IDLE;
        s_d.cnt        = '0;
        s_d.load_after = 1'b0;
        s_d.wr_n       = 1'b1;
        s_d.ld_n       = 1'b1;
        s_d.a0_oe      = 1'b1;
        s_d.pd         = 1'b0;
        s_d.busy       = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      // device registers are zero; keep strobes idle and bus driven with zero
      s_q.st         <= QDH_IDLE;
      s_q.cnt        <= '0;
      s_q.data       <= DATA_RST;
      s_q.addr       <= ADDR_RST;
      s_q.load_after <= 1'b0;
      s_q.wr_n       <= 1'b1;
      s_q.ld_n       <= 1'b1;
      s_q.a0_oe      <= 1'b1;
      s_q.pd         <= 1'b0;
      s_q.busy       <= 1'b0;
      s_q.done       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Device pins
  assign data_bus                 = s_q.data;
  assign addr_high_bit            = s_q.addr[1];
  assign addr_low_or_powerdown_o  = s_q.addr[0];
  assign addr_low_or_powerdown_oe = s_q.a0_oe;
  assign write_strobe_n           = s_q.wr_n;
  assign load_all_strobe_n        = s_q.ld_n;
  // User status
  assign busy                     = s_q.busy;
  assign done                     = s_q.done;
  assign powered_down             = s_q.pd;
endmodule // qdh_host

// [verif/qdh_dev_model.sv]
// Behavioural model of the quad converter digital front end
module qdh_dev_model (
  // Host pins
  input  wire logic [7:0] data_bus,
  input  wire logic       a1, a0, a0_oe, wr_n, ld_n,
  // Observed state
  output logic      [7:0] dac [4],
  output logic            hiz
);
  logic [7:0] inr [4];
  initial begin
    inr = '{default: 8'h00};
    dac = '{default: 8'h00};
  end
  always @* begin
    if (!wr_n && a0_oe) inr[{a1, a0}] = data_bus;
    if (!ld_n) dac = inr;
  end
  // Shutdown touches no register, so codes come back on wake
  assign hiz = !a0_oe;
endmodule // qdh_dev_model

// [verif/qdh_host_assertions.sv]
// Checker for the quad converter host controller
module qdh_host_chk (
  input wire logic mclk, reset, req_valid, req_load, load_only, transparent, power_down,
  input wire logic busy, done, powered_down, addr_low_or_powerdown_oe,
  input wire logic write_strobe_n, load_all_strobe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic tk;
  assign tk = req_valid && !busy && !done && !power_down && !powered_down;
  property p_wt; tk && !load_only && (!req_load || transparent) |-> ##7 done; endproperty
  a_wt: assert property (p_wt) else $error("write time");
  property p_wl; tk && !load_only && req_load && !transparent |-> ##11 done; endproperty
  a_wl: assert property (p_wl) else $error("write and load time");
  property p_lo; tk && load_only && !transparent |-> ##5 done; endproperty
  a_lo: assert property (p_lo) else $error("load time");
  property p_ws; $fell(write_strobe_n) |-> !write_strobe_n[*3] ##1 write_strobe_n; endproperty
  a_ws: assert property (p_ws) else $error("write strobe width");
  property p_ad; !write_strobe_n |-> addr_low_or_powerdown_oe; endproperty
  a_ad: assert property (p_ad) else $error("strobe without address");
  property p_nl; !transparent && $fell(write_strobe_n) |-> load_all_strobe_n; endproperty
  a_nl: assert property (p_nl) else $error("load during write");
  property p_tr; !$past(reset) && $past(transparent) && transparent && !busy && !$past(busy)
    |-> !load_all_strobe_n; endproperty
  a_tr: assert property (p_tr) else $error("not transparent");
  property p_pd; powered_down |-> !addr_low_or_powerdown_oe && write_strobe_n; endproperty
  a_pd: assert property (p_pd) else $error("driving in shutdown");
  property p_pr; $rose(powered_down) |-> $past(power_down) && !$past(busy); endproperty
  a_pr: assert property (p_pr) else $error("shutdown unasked");
  c_lo: cover property (tk && load_only);
  c_wl: cover property (tk && req_load);
  c_pd: cover property ($rose(powered_down));
endmodule // qdh_host_chk
bind qdh_host qdh_host_chk i_chk (.mclk, .reset, .req_valid, .req_load, .load_only,
  .transparent, .power_down, .busy, .done, .powered_down, .addr_low_or_powerdown_oe,
  .write_strobe_n, .load_all_strobe_n);

// [verif/test_qdh_host.sv]
// Testbench for the quad converter host controller
module test_qdh_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, rv = 0, rl = 0, lo = 0, tr = 0, pdn = 0;
  logic busy, done, pd, a1, a0, oe, wn, ln, hiz;
  logic [1:0] ch = 0;
  logic [7:0] rd = 0, db, dac [4];
  int fails = 0, compares = 0, n;
  always #10 mclk = ~mclk;
  qdh_host i_qdh_host (.mclk, .reset, .req_valid(rv), .req_chan(ch), .req_data(rd),
    .req_load(rl), .load_only(lo), .transparent(tr), .power_down(pdn), .busy, .done,
    .powered_down(pd), .data_bus(db), .addr_high_bit(a1), .addr_low_or_powerdown_o(a0),
    .addr_low_or_powerdown_oe(oe), .write_strobe_n(wn), .load_all_strobe_n(ln));
  qdh_dev_model i_dev (.data_bus(db), .a1, .a0, .a0_oe(oe), .wr_n(wn), .ld_n(ln), .dac, .hiz);
  task report_and_stop;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task req(input logic [1:0] c, input logic [7:0] d, input logic l, o, int lat);
    {ch, rd, rl, lo, rv} = {c, d, l, o, 1'b1};
    n = 0;
    do begin
      @(negedge mclk);
      rv = 0;
      n++;
    end while (done !== 1'b1 && n < 40);
    if (done !== 1'b1) begin
      fails++;
      report_and_stop;
    end
    if (lat > 0) chk(8'(n), 8'(lat));
    @(negedge mclk);
  endtask
  task reset_zero;
    for (int i = 0; i < 4; i++) chk(dac[i], 8'h00);
  endtask
  task buffered;
    for (int i = 0; i < 4; i++) req(2'(i), 8'h81 + 8'(i), 0, 0, 7);
    reset_zero();
    req(0, 0, 0, 1, 5);
    for (int i = 0; i < 4; i++) chk(dac[i], 8'h81 + 8'(i));
    req(2, 8'h5c, 1, 0, 11);
    chk(dac[2], 8'h5c);
  endtask
  task transparent_mode;
    tr = 1;
    repeat (3) @(negedge mclk);
    req(3, 8'h3e, 1, 0, 7);
    chk(dac[3], 8'h3e);
    tr = 0;
  endtask
  task shutdown;
    pdn = 1;
    repeat (4) @(negedge mclk);
    chk({pd, hiz}, 2'b11);
    rv = 1;
    repeat (12) @(negedge mclk);
    chk({busy, wn}, 2'b01);
    {rv, pdn} = 0;
    repeat (4) @(negedge mclk);
    chk({busy, pd, hiz}, 3'b000);
    chk(dac[3], 8'h3e);
    req(0, 0, 0, 1, 5);
    chk(dac[0], 8'h81);
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    reset = 0;
    @(negedge mclk);
    reset_zero();
    buffered();
    transparent_mode();
    shutdown();
    report_and_stop;
  end
endmodule // test_qdh_host
